// >>> verilog/bxc_pkg.sv
// bxc_pkg.sv - constants of the execution unit, including the cycle counts from which it derives its timer loads
// assumes: used as bxc_pkg::name everywhere, never imported
package bxc_pkg;
   // ********************************************
   // register offsets, byte addresses on the bus
   // ********************************************
   localparam logic [7:0] OFF_FLAGS  = 8'h00;
   localparam logic [7:0] OFF_ACCUM  = 8'h04;
   localparam logic [7:0] OFF_INDEX  = 8'h08;
   localparam logic [7:0] OFF_SP     = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_TARGET = 8'h14;

   // ********************************************
   // field positions
   // ********************************************
   localparam int FLAG_CARRY  = 0;
   localparam int FLAG_ERB    = 1;
   localparam int FLAG_EMB    = 2;
   localparam int STAT_BUSY   = 0;
   localparam int STAT_SKIP   = 1;

   // ********************************************
   // values after reset
   // ********************************************
   localparam logic       RST_BIT = 1'h0;
   localparam logic [3:0] RST_NIB = 4'h0;
   localparam logic [7:0] RST_SP  = 8'h00;

   // ********************************************
   // opcodes and operand forms
   // ********************************************
   localparam logic [7:0] OPC_BIT_XOR_INTO_CARRY    = 8'hF7;
   localparam logic [7:0] OPC_BIT_TEST_SKIP_CLEAR   = 8'hFD;
   localparam logic [7:0] OPC_LONG    = 8'hDB;
   localparam logic [1:0] OPC_LONG_B1 = 2'h1;
   localparam logic [4:0] OPC_SHORT   = 5'h1D;
   localparam logic [7:0] OPC_CCF     = 8'hD6;
   localparam logic [7:0] OPC_COM     = 8'hDD;
   localparam logic [7:0] OPC_COM_B2  = 8'h3F;
   localparam logic [3:0] FORM_IDX    = 4'h4;
   localparam logic [1:0] FORM_PAGE   = 2'h0;
   localparam logic [7:0] DIR_PAGE_LO = 8'hFB;
   localparam logic [7:0] DIR_PAGE_HI = 8'hFF;
   localparam logic [5:0] IDX_BANK    = 6'h3F;
   localparam logic [3:0] PAGE_BANK   = 4'h0;

   // ********************************************
   // cycle counts and stack frame
   // ********************************************
   localparam logic [2:0]  CYC_BIT     = 3'h2;
   localparam logic [2:0]  CYC_CLEAR   = 3'h1;
   localparam logic [2:0]  CYC_LONG    = 3'h4;
   localparam logic [2:0]  CYC_SHORT   = 3'h3;
   localparam logic [2:0]  CYC_COM     = 3'h2;
   localparam logic [7:0]  FRAME_DEPTH = 8'h06;
   localparam logic [13:0] RET_LONG    = 14'h0003;
   localparam logic [13:0] RET_SHORT   = 14'h0002;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_READ  = 5'h02,
      ST_CLEAR = 5'h04,
      ST_CALL  = 5'h08,
      ST_WAIT  = 5'h10
   } bxc_state_t;
endpackage : bxc_pkg

// >>> verilog/bxc_seq_if.sv
// bxc_seq_if.sv - link between the sequencer and its cycle timer
// assumes: both ends run on ref_clk
`timescale 1ns/10ps
interface bxc_seq_if;
   logic       start;   // load the timer
   logic [2:0] span;    // cycles still to run after this one
   logic       busy;    // timer running
   logic       last;    // final busy cycle
   modport ctl (output start, output span, input busy, input last);
   modport tmr (input start, input span, output busy, output last);
endinterface : bxc_seq_if

// >>> verilog/bxc_cycle_timer.sv
// bxc_cycle_timer.sv - down counter that stretches multi-cycle instructions
// assumes: start is a one-cycle request from the sequencer on the same clock
`timescale 1ns/10ps
module bxc_cycle_timer (
   input wire logic ref_clk,  // core clock
   input wire logic rst,      // synchronous reset, high
   input wire logic ce,       // freezes the count while low
   bxc_seq_if.tmr   seq       // sequencer side
);
   logic [2:0] remaining;

   // ********************************************
   // count down; a fresh start wins over the running count
   // ********************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         remaining <= 3'h0;
      end else if (ce) begin
         if (seq.start) begin
            remaining <= seq.span;
         end else if (remaining != 3'h0) begin
            remaining <= remaining - 3'h1;
         end
      end
   end

   // status back to the sequencer
   assign seq.busy = (remaining != 3'h0);
   assign seq.last = (remaining == 3'h1);
endmodule : bxc_cycle_timer

// >>> verilog/bxc_core.sv
// bxc_core.sv - executes bit xor into carry, bit test skip clear, long and
// short calls, carry inversion and accumulator inversion
// assumes: fetch offers one instruction with its address per handshake,
// data memory answers reads in the same cycle, the stack ram takes a whole
// six nibble frame in one write, one ahb-lite master
`timescale 1ns/10ps
// Functional notes
// - bit xor puts carry xor memory bit into carry; two bytes, two cycles
// - indexed form: address from operand bits and L[3:2], bit from L[1:0]
// - page form: H is upper nibble, operand low nibble, operand bit field
// - long call: three bytes, four cycles, return pc plus three, then jump
// - long call also pushes both bank flags; stack pointer drops by six
// - frame: flags at sp-1/-2, pc 7-0 at -3/-4, pc 13-8 at -5/-6
// - nibbles downward: 0, 00+flags, pc7-4, pc3-0, 00+pc13-12, pc11-8
// - long call target is the full 14-bit field, whole program space
// - short call: two bytes, three cycles, return pc plus two, six nibbles
// - short call loads low 11 pc bits, clears the rest
// - short frame: pc 10-8 at sp-6, upper address nibble written as zero
// - carry invert flips carry; one byte, one cycle
// - accumulator invert flips all four bits; two bytes, two cycles
// - bit test skip clear: if bit is one, clear it and skip next
// - direct form: prefix 10 selects FB0H-FBFH, prefix 11 FF0H-FFFH
module bxc_core (
   input  wire logic        ref_clk,      // 50 mhz core clock
   input  wire logic        rst,          // synchronous reset, high
   input  wire logic        ce,           // freezes all state while low
   input  wire logic        hsel,         // ahb slave select
   input  wire logic [31:0] haddr,        // ahb address
   input  wire logic [1:0]  htrans,       // ahb transfer type
   input  wire logic        hwrite,       // ahb write
   input  wire logic [2:0]  hsize,        // ahb size, word only
   input  wire logic        hready,       // ahb bus ready
   input  wire logic [31:0] hwdata,       // ahb write data
   output logic             hreadyout,    // ahb slave ready
   output logic [31:0]      hrdata,       // ahb read data
   output logic             hresp,        // ahb response, always okay
   input  wire logic        instr_valid,  // fetch offers an instruction
   output logic             instr_ready,  // unit takes it
   input  wire logic [7:0]  instr_b0,     // first byte
   input  wire logic [7:0]  instr_b1,     // second byte
   input  wire logic [7:0]  instr_b2,     // third byte
   input  wire logic [13:0] instr_pc,     // address of the first byte
   output logic [11:0]      mem_addr,     // data memory nibble address
   output logic             mem_re,       // read cycle
   input  wire logic [3:0]  mem_rdata,    // read nibble, same cycle
   output logic             mem_we,       // write cycle
   output logic [3:0]       mem_wdata,    // write nibble
   output logic             stk_we,       // frame write
   output logic [7:0]       stk_addr,     // lowest frame address
   output logic [23:0]      stk_frame,    // six nibbles, [3:0] lowest
   output logic             jump_valid,   // pc takes jump_target
   output logic [13:0]      jump_target,  // call target
   output logic             skip_pending  // next instruction is skipped
);
   // ********************************************
   // state
   // ********************************************
   bxc_pkg::bxc_state_t state;
   bxc_pkg::bxc_state_t next_state;
   logic        carry;
   logic        memory_bank_enable_flag;
   logic        register_bank_enable_flag;
   logic [3:0]  acc;
   logic [3:0]  h;
   logic [3:0]  l;
   logic [7:0]  sp;
   logic [1:0]  bsel;
   logic        cur_bit_test_skip_clear;
   logic        wr_pend;
   logic [7:0]  wr_off;
   logic [31:0] rd_word;
   bxc_seq_if   seq ();

   // ********************************************
   // decode
   // ********************************************
   logic        accept;
   logic        run;
   logic        is_bit_xor_into_carry;
   logic        is_bit_test_skip_clear;
   logic        is_long;
   logic        is_short;
   logic        is_ccf;
   logic        is_com;
   logic        fm_dir;
   logic        fm_idx;
   logic        fm_page;
   logic        bit_go;
   logic        long_go;
   logic        short_go;
   logic        call_go;
   logic        ccf_go;
   logic        com_go;
   logic [11:0] ea;
   logic [1:0]  ea_bit;

   // opcode match; skipped instructions are consumed without effect
   assign is_bit_xor_into_carry  = (instr_b0 == bxc_pkg::OPC_BIT_XOR_INTO_CARRY);
   assign is_bit_test_skip_clear = (instr_b0 == bxc_pkg::OPC_BIT_TEST_SKIP_CLEAR);
   assign is_long  = (instr_b0 == bxc_pkg::OPC_LONG) &&
                     (instr_b1[7:6] == bxc_pkg::OPC_LONG_B1);
   assign is_short = (instr_b0[7:3] == bxc_pkg::OPC_SHORT);
   assign is_ccf   = (instr_b0 == bxc_pkg::OPC_CCF);
   assign is_com   = (instr_b0 == bxc_pkg::OPC_COM) &&
                     (instr_b1 == bxc_pkg::OPC_COM_B2);
   assign accept   = instr_valid && instr_ready;
   assign run      = accept && !skip_pending;

   // operand form of the second byte; other patterns make a no-op
   assign fm_dir  = instr_b1[7];
   assign fm_idx  = (instr_b1[7:4] == bxc_pkg::FORM_IDX);
   assign fm_page = (instr_b1[7:6] == bxc_pkg::FORM_PAGE);

   // effective nibble address and bit of the three forms
   assign ea = fm_dir ? {(instr_b1[6] ? bxc_pkg::DIR_PAGE_HI : bxc_pkg::DIR_PAGE_LO),
                         instr_b1[3:0]} :
               fm_idx ? {bxc_pkg::IDX_BANK, instr_b1[3:0], l[3:2]} :
                        {bxc_pkg::PAGE_BANK, h, instr_b1[3:0]};
   assign ea_bit = fm_idx ? l[1:0] : instr_b1[5:4];

   // instruction starts
   assign bit_go   = run && (is_bit_xor_into_carry || is_bit_test_skip_clear) && (fm_dir || fm_idx || fm_page);
   assign long_go  = run && is_long;
   assign short_go = run && is_short;
   assign call_go  = long_go || short_go;
   assign ccf_go   = run && is_ccf;
   assign com_go   = run && is_com;

   // ********************************************
   // execution cycle
   // ********************************************
   logic        st_read;
   logic        bit_val;
   logic        xor_done;
   logic        clr_hit;
   logic [13:0] ret_addr;
   logic [23:0] frame;
   logic [13:0] target;

   assign st_read  = (state == bxc_pkg::ST_READ) && ce;
   assign bit_val  = mem_rdata[bsel];
   assign xor_done = st_read && !cur_bit_test_skip_clear;
   assign clr_hit  = st_read && cur_bit_test_skip_clear && bit_val;

   // return address and frame, highest nibble first
   assign ret_addr = instr_pc + (is_long ? bxc_pkg::RET_LONG : bxc_pkg::RET_SHORT);
   assign frame = is_long ?
      {4'h0, 2'h0, memory_bank_enable_flag, register_bank_enable_flag, ret_addr[7:4], ret_addr[3:0],
       2'h0, ret_addr[13:12], ret_addr[11:8]} :
      {4'h0, 2'h0, memory_bank_enable_flag, register_bank_enable_flag, ret_addr[7:4], ret_addr[3:0],
       4'h0, 1'h0, ret_addr[10:8]};
   assign target = is_long ? {instr_b1[5:0], instr_b2} :
                             {3'h0, instr_b0[2:0], instr_b1};

   // timer load: remaining busy cycles after the accept cycle, or after the read cycle for a clear
   assign seq.start = bit_go || call_go || com_go || clr_hit;
   assign seq.span  = clr_hit  ? bxc_pkg::CYC_CLEAR :
                      long_go  ? bxc_pkg::CYC_LONG - 3'h1 :
                      short_go ? bxc_pkg::CYC_SHORT - 3'h1 :
                      com_go   ? bxc_pkg::CYC_COM - 3'h1 :
                                 bxc_pkg::CYC_BIT - 3'h1;

   bxc_cycle_timer u_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .seq     (seq.tmr)
   );

   // fetch is held until the frame is written and the pc has moved
   assign instr_ready = ce && (state == bxc_pkg::ST_IDLE) && !seq.busy;
   assign jump_valid  = ce && (state == bxc_pkg::ST_CALL) && seq.last;

   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         bxc_pkg::ST_IDLE: begin
            if (bit_go) begin
               next_state = bxc_pkg::ST_READ;
            end else if (call_go) begin
               next_state = bxc_pkg::ST_CALL;
            end else if (com_go) begin
               next_state = bxc_pkg::ST_WAIT;
            end
         end
         bxc_pkg::ST_READ: begin
            next_state = clr_hit ? bxc_pkg::ST_CLEAR : bxc_pkg::ST_IDLE;
         end
         bxc_pkg::ST_CLEAR, bxc_pkg::ST_CALL, bxc_pkg::ST_WAIT: begin
            if (seq.last) begin
               next_state = bxc_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = bxc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= bxc_pkg::ST_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ********************************************
   // ahb-lite slave, zero wait states while ce is high
   // ********************************************
   logic ap_take;
   logic wr_flags;
   logic wr_acc;
   logic wr_idx;
   logic wr_sp;

   // ce low stretches the transfer so no bus state changes under freeze
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign ap_take   = ce && hsel && hready && htrans[1];
   assign wr_flags  = ce && wr_pend && (wr_off == bxc_pkg::OFF_FLAGS);
   assign wr_acc    = ce && wr_pend && (wr_off == bxc_pkg::OFF_ACCUM);
   assign wr_idx    = ce && wr_pend && (wr_off == bxc_pkg::OFF_INDEX);
   assign wr_sp     = ce && wr_pend && (wr_off == bxc_pkg::OFF_SP);

   // read word; unmapped offsets read as zero
   always_comb begin
      rd_word = 32'h0;
      case (haddr[7:0])
         bxc_pkg::OFF_FLAGS: begin
            rd_word[bxc_pkg::FLAG_CARRY] = carry;
            rd_word[bxc_pkg::FLAG_ERB]   = register_bank_enable_flag;
            rd_word[bxc_pkg::FLAG_EMB]   = memory_bank_enable_flag;
         end
         bxc_pkg::OFF_ACCUM:  rd_word[3:0]  = acc;
         bxc_pkg::OFF_INDEX:  rd_word[7:0]  = {h, l};
         bxc_pkg::OFF_SP:     rd_word[7:0]  = sp;
         bxc_pkg::OFF_STATUS: begin
            rd_word[bxc_pkg::STAT_BUSY] = (state != bxc_pkg::ST_IDLE);
            rd_word[bxc_pkg::STAT_SKIP] = skip_pending;
         end
         bxc_pkg::OFF_TARGET: rd_word[13:0] = jump_target;
         default:             rd_word = 32'h0;
      endcase
   end

   // address phase capture; read data is sampled here for the data phase
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_pend <= 1'b0;
         wr_off  <= 8'h00;
         hrdata  <= 32'h0;
      end else if (ce) begin
         wr_pend <= ap_take && hwrite;
         wr_off  <= haddr[7:0];
         if (ap_take && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   // ********************************************
   // cpu registers; instruction updates win over a bus write
   // ********************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         carry <= bxc_pkg::RST_BIT;
         memory_bank_enable_flag   <= bxc_pkg::RST_BIT;
         register_bank_enable_flag   <= bxc_pkg::RST_BIT;
      end else if (ccf_go) begin
         carry <= ~carry;
      end else if (xor_done) begin
         carry <= carry ^ bit_val;
      end else if (wr_flags) begin
         carry <= hwdata[bxc_pkg::FLAG_CARRY];
         memory_bank_enable_flag   <= hwdata[bxc_pkg::FLAG_EMB];
         register_bank_enable_flag   <= hwdata[bxc_pkg::FLAG_ERB];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         acc <= bxc_pkg::RST_NIB;
         h   <= bxc_pkg::RST_NIB;
         l   <= bxc_pkg::RST_NIB;
      end else begin
         if (com_go) begin
            acc <= ~acc;
         end else if (wr_acc) begin
            acc <= hwdata[3:0];
         end
         if (wr_idx) begin
            h <= hwdata[7:4];
            l <= hwdata[3:0];
         end
      end
   end

   // stack pointer drops by a whole frame on either call
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sp <= bxc_pkg::RST_SP;
      end else if (call_go) begin
         sp <= sp - bxc_pkg::FRAME_DEPTH;
      end else if (wr_sp) begin
         sp <= hwdata[7:0];
      end
   end

   // skip flag: set by a cleared bit, spent by the next instruction taken
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         skip_pending <= bxc_pkg::RST_BIT;
      end else if (clr_hit) begin
         skip_pending <= 1'b1;
      end else if (accept) begin
         skip_pending <= 1'b0;
      end
   end

   // ********************************************
   // memory, stack and jump outputs
   // ********************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_addr  <= 12'h000;
         mem_re    <= 1'b0;
         mem_we    <= 1'b0;
         mem_wdata <= 4'h0;
         bsel      <= 2'h0;
         cur_bit_test_skip_clear <= 1'b0;
      end else if (ce) begin
         mem_re <= bit_go;
         mem_we <= clr_hit;
         if (bit_go) begin
            mem_addr  <= ea;
            bsel      <= ea_bit;
            cur_bit_test_skip_clear <= is_bit_test_skip_clear;
         end
         if (clr_hit) begin
            mem_wdata       <= mem_rdata;
            mem_wdata[bsel] <= 1'b0;
         end
      end
   end

   // the whole frame goes out in the first busy cycle of a call
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stk_we      <= 1'b0;
         stk_addr    <= 8'h00;
         stk_frame   <= 24'h0;
         jump_target <= 14'h0;
      end else if (ce) begin
         stk_we <= call_go;
         if (call_go) begin
            stk_addr    <= sp - bxc_pkg::FRAME_DEPTH;
            stk_frame   <= frame;
            jump_target <= target;
         end
      end
   end

   // ********************************************
   // assertions
   // ********************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // independent return address for the long frame check
   logic [13:0] ret_plus3;
   assign ret_plus3 = instr_pc + 14'h0003;

   sequence s_long_go;
      long_go;
   endsequence
   sequence s_short_go;
      short_go;
   endsequence
   sequence s_long_run;
      s_long_go ##1 ce [*3];
   endsequence

   property p_bit_xor_into_carry_carry;
      xor_done |=> carry == ($past(carry) ^ $past(bit_val));
   endproperty
   a_bit_xor_into_carry_carry: assert property (p_bit_xor_into_carry_carry) else $error("bit_xor_into_carry carry wrong");

   property p_idx_addr;
      (bit_go && fm_idx) |=> mem_re && mem_addr == {6'h3F, $past(instr_b1[3:0]), $past(l[3:2])}
                             && bsel == $past(l[1:0]);
   endproperty
   a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

   property p_page_addr;
      (bit_go && fm_page) |=> mem_addr == {4'h0, $past(h), $past(instr_b1[3:0])}
                              && bsel == $past(instr_b1[5:4]);
   endproperty
   a_page_addr: assert property (p_page_addr) else $error("page address wrong");

   property p_dir_addr;
      (bit_go && fm_dir) |=> mem_addr[11:4] == ($past(instr_b1[6]) ? 8'hFF : 8'hFB);
   endproperty
   a_dir_addr: assert property (p_dir_addr) else $error("direct page wrong");

   property p_long_hold;
      s_long_go |=> (!instr_ready) [*3];
   endproperty
   a_long_hold: assert property (p_long_hold) else $error("long call too short");

   property p_long_done;
      s_long_run |-> jump_valid ##1 (instr_ready || !ce);
   endproperty
   a_long_done: assert property (p_long_done) else $error("long call not four cycles");

   property p_short_done;
      s_short_go ##1 ce [*2] |-> jump_valid ##1 (instr_ready || !ce);
   endproperty
   a_short_done: assert property (p_short_done) else $error("short call not three cycles");

   property p_long_frame;
      s_long_go |=> stk_we && stk_addr == $past(sp) - 8'h06 && stk_frame ==
         {6'h00, $past(memory_bank_enable_flag), $past(register_bank_enable_flag), $past(ret_plus3[7:0]), 2'h0, $past(ret_plus3[13:8])};
   endproperty
   a_long_frame: assert property (p_long_frame) else $error("long frame wrong");

   property p_long_target;
      s_long_go |=> jump_target == $past({instr_b1[5:0], instr_b2});
   endproperty
   a_long_target: assert property (p_long_target) else $error("long target wrong");

   property p_short_frame;
      s_short_go |=> stk_frame[7:3] == 5'h00 && jump_target[13:11] == 3'h0;
   endproperty
   a_short_frame: assert property (p_short_frame) else $error("short frame wrong");

   property p_sp_drop;
      call_go |=> sp == $past(sp) - 8'h06;
   endproperty
   a_sp_drop: assert property (p_sp_drop) else $error("stack pointer not down six");

   property p_ccf;
      ccf_go |=> carry != $past(carry) && !seq.busy;
   endproperty
   a_ccf: assert property (p_ccf) else $error("carry not inverted");

   property p_com;
      com_go |=> acc == ~$past(acc) && !instr_ready;
   endproperty
   a_com: assert property (p_com) else $error("accumulator not inverted");

   property p_bit_test_skip_clear;
      clr_hit |=> mem_we && mem_wdata[bsel] == 1'b0 && skip_pending && !instr_ready;
   endproperty
   a_bit_test_skip_clear: assert property (p_bit_test_skip_clear) else $error("bit not cleared or no skip");
endmodule : bxc_core

// >>> dv/bit_xor_call_carry_ops_tb_top.sv
// bench for bxc_core: calls, bit xor, bit test clear, carry and accumulator invert
// assumes: bxc_pkg compiled first, bench is the only ahb master, memory reads settle
`timescale 1ns/10ps
module bit_xor_call_carry_ops_tb_top;
   logic        ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, iv = 0, ir, hro, hresp;
   logic        mre, mwe, swe, jv, skp, c, ce = 1;
   logic [1:0]  htrans = 0, f;
   logic [3:0]  nib = 0, mwd, wd_s, a;
   logic [7:0]  b0 = 0, b1 = 0, b2 = 0, sa, sa_s, s, o, x;
   logic [11:0] ma, ma_s;
   logic [13:0] pc = 0, jt, jt_s, t;
   logic [23:0] sf, sf_s;
   logic [31:0] haddr = 0, hwdata = 0, hrd, r;
   int          fails = 0, checks_done = 0, cyc, tmo = 0;
   always #10 ref_clk = ~ref_clk;
   bxc_core i_bxc_core (.ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hro), .hwdata(hwdata),
      .hreadyout(hro), .hrdata(hrd), .hresp(hresp), .instr_valid(iv), .instr_ready(ir),
      .instr_b0(b0), .instr_b1(b1), .instr_b2(b2), .instr_pc(pc), .mem_addr(ma),
      .mem_re(mre), .mem_rdata(nib), .mem_we(mwe), .mem_wdata(mwd), .stk_we(swe),
      .stk_addr(sa), .stk_frame(sf), .jump_valid(jv), .jump_target(jt), .skip_pending(skp));
   // strobes last one cycle, so latch them; the timeout guards every wait
   always @(posedge ref_clk) begin
      if (mre) ma_s <= ma;
      if (mwe) wd_s <= mwd;
      if (swe) {sa_s, sf_s} <= {sa, sf};
      if (jv) jt_s <= jt;
      if (++tmo == 6000) begin
         fails++;
         complete_run();
      end
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] v);
      checks_done++;
      if (v !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, v);
      end
   endtask : chk
   // one single word transfer; read data taken at the data phase edge
   task automatic ahb(logic w, logic [7:0] ad, logic [31:0] d);
      hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, ad};
      do @(posedge ref_clk); while (hro !== 1);
      hsel <= 0; htrans <= 0; hwdata <= d;
      do @(posedge ref_clk); while (hro !== 1);
      r = hrd;
   endtask : ahb
   // offer one instruction, count cycles until the unit is ready again
   task automatic ex(logic [7:0] c0, logic [7:0] c1, logic [7:0] c2);
      b0 <= c0; b1 <= c1; b2 <= c2; iv <= 1;
      do @(posedge ref_clk); while (ir !== 1);
      iv <= 0;
      cyc = 1;
      @(posedge ref_clk);
      while (ir !== 1) begin
         cyc++;
         @(posedge ref_clk);
      end
   endtask : ex
   function automatic logic [23:0] frm(logic lg, logic [1:0] fl, logic [13:0] p);
      return {6'h0, fl, p[7:0], lg ? {2'h0, p[13:8]} : {5'h0, p[10:8]}};
   endfunction : frm
   function automatic logic [11:0] ba(logic [7:0] op, logic [7:0] hl);
      if (op[7]) return {4'hF, op[6] ? 4'hF : 4'hB, op[3:0]};
      if (op[6]) return {6'h3F, op[3:0], hl[3:2]};
      return {4'h0, hl[7:4], op[3:0]};
   endfunction : ba
   function automatic logic [1:0] bi(logic [7:0] op, logic [7:0] hl);
      return (op[7] | !op[6]) ? op[5:4] : hl[1:0];
   endfunction : bi
   task automatic complete_run;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // ********************
   // main sequence
   // ********************
   initial begin
      void'($urandom(11869));
      repeat (20) @(posedge ref_clk);
      rst <= 0;
      repeat (4) begin
         f = $urandom; s = $urandom; t = $urandom; pc <= $urandom;
         ahb(1, 8'h00, {f, 1'b0});
         ahb(1, 8'h0C, s);
         ex(8'hDB, {2'h1, t[13:8]}, t[7:0]);
         chk("long cycles", 4, cyc);
         chk("long frame", frm(1, f, pc + 3), sf_s);
         chk("long addr", 8'(s - 8'h06), sa_s);
         chk("long target", t, jt_s);
         ex({5'h1D, t[10:8]}, t[7:0], 0);
         chk("short cycles", 3, cyc);
         chk("short frame", frm(0, f, pc + 2), sf_s);
         chk("short target", t[10:0], jt_s);
         chk("short addr", 8'(s - 8'h0C), sa_s);
         ahb(0, 8'h0C, 0);
         chk("sp", 8'(s - 8'h0C), r);
         ahb(0, 8'h14, 0);
         chk("target reg", t[10:0], r);
      end
      $display("calls done");
      for (int k = 0; k < 9; k++) begin
         o = k % 3 == 0 ? {2'h0, 6'($urandom)} : k % 3 == 1 ? {4'h4, 4'($urandom)}
            : {1'h1, 7'($urandom)};
         x = $urandom; nib <= $urandom; c = $urandom;
         ahb(1, 8'h08, x);
         ahb(1, 8'h00, c);
         ex(8'hF7, o, 0);
         chk("xor cycles", 2, cyc);
         chk("xor addr", ba(o, x), ma_s);
         ahb(0, 8'h00, 0);
         chk("xor carry", c ^ nib[bi(o, x)], r);
      end
      $display("bit xor done");
      c = r[0];
      ex(8'hD6, 0, 0);
      chk("ccf cycles", 1, cyc);
      ahb(0, 8'h00, 0);
      chk("ccf carry", !c, r);
      a = $urandom;
      ahb(1, 8'h04, a);
      ex(8'hDD, 8'h3F, 0);
      chk("com cycles", 2, cyc);
      ahb(0, 8'h04, 0);
      chk("com acc", 4'(~a), r);
      // clock enable low for three cycles stretches the busy phase, one inversion only
      fork
         ex(8'hDD, 8'h3F, 0);
         begin
            @(posedge ref_clk);
            ce <= 1'b0;
            repeat (3) @(posedge ref_clk);
            ce <= 1'b1;
         end
      join
      chk("freeze cycles", 5, cyc);
      ahb(0, 8'h04, 0);
      chk("freeze acc", a, r);
      $display("invert done");
      o = {2'h0, 6'($urandom)};
      nib <= 4'hF;
      ex(8'hFD, o, 0);
      chk("clear cycles", 3, cyc);
      chk("clear data", 4'hF ^ (4'h1 << o[5:4]), wd_s);
      chk("skip set", 1, skp);
      ahb(0, 8'h10, 0);
      chk("status skip", 2, r);
      ex(8'hD6, 0, 0);
      ahb(0, 8'h00, 0);
      chk("skipped ccf", !c, r);
      chk("skip clear", 0, skp);
      // a clear bit is left alone and the next instruction runs
      nib <= 4'h0;
      ex(8'hFD, o, 0);
      chk("keep cycles", 2, cyc);
      chk("no skip", 0, skp);
      $display("skip done");
      chk("hresp", 0, hresp);
      complete_run();
   end
endmodule : bit_xor_call_carry_ops_tb_top
